// >>> include/lirh_defs.svh
// Register map, field layout and reset values of the local interrupt routing hub
// Function
// - Both local pins accept edge- or level-style requests, chosen per entry.
// - Every local source has its own vector table entry.
// - A pin entry in non-maskable mode delivers vector 2 to the core.
// - Writing the command register low word issues one inter-processor message when none is still pending.
// - Messages go out on the system bus or the dedicated interrupt bus.
// - Messages may target other processors or this processor itself.
// - Received messages go to the core with their vector and trigger mode.
// - The timer raises a local interrupt when its count runs out.
// - Performance counter overflow can raise a local interrupt.
// - Thermal trip can raise a local interrupt.
// - Illegal register access is flagged and can raise an error interrupt.
// - When disabled, the core takes legacy controller interrupts directly.
// - Registers are memory mapped and reached by plain loads and stores.
// - Registers decode in a 4 KByte page based at FEE00000H.
`ifndef LIRH_DEFS_SVH
`define LIRH_DEFS_SVH
`define LIRH_BASE_ADDR   32'hFEE0_0000
`define LIRH_OFF_ID      12'h020
`define LIRH_OFF_CTRL    12'h0F0
`define LIRH_OFF_ERR     12'h280
`define LIRH_OFF_ICR_LO  12'h300
`define LIRH_OFF_ICR_HI  12'h310
`define LIRH_OFF_LVT0    12'h320
`define LIRH_OFF_TINIT   12'h380
`define LIRH_OFF_TCUR    12'h390
`define LIRH_OFF_PEND    12'h3A0
`define LIRH_LVT_STEP    8'h32
`define LIRH_F_TRIG      15
`define LIRH_F_MASK      16
`define LIRH_F_BUSY      12
`define LIRH_F_SELF      18
`define LIRH_F_EN        8
`define LIRH_F_SYSBUS    9
`define LIRH_F_ILLEGAL   7
`define LIRH_MODE_NMI    3'h4
`define LIRH_VEC_NMI     8'h02
`define LIRH_DEST_ALL    8'hFF
`define LIRH_LVT_RST     17'h1_0000
`define LIRH_RESP_OK     2'h0
`define LIRH_RESP_ERR    2'h2
`define LIRH_SRC_RX      3'h6
`define LIRH_SRC_LEGACY  3'h7
`endif

// >>> include/lirh_pkg.sv
// Types shared by the local interrupt routing hub
package lirh_pkg;
	typedef enum logic {LIRH_DLV_IDLE, LIRH_DLV_BUSY} lirh_dlv_e;
	typedef logic [16:0] lirh_lvt_t;
endpackage : lirh_pkg

// >>> rtl/lirh_hub.sv
// Local interrupt routing hub: AXI4-Lite registers, sources, messages, core delivery
`include "lirh_defs.svh"
module lirh_hub import lirh_pkg::*; #(
	parameter int         NSRC   = 6,
	parameter logic [7:0] ID_RST = 8'h00
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// AXI4-Lite register port
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Local pins and internal sources
	input  wire logic        local_irq_pin_zero,
	input  wire logic        local_irq_pin_one,
	input  wire logic        perf_ovf,
	input  wire logic        thermal_trip,
	// Legacy controller
	input  wire logic        legacy_irq,
	input  wire logic [7:0]  legacy_vector,
	// Outgoing messages
	output logic             msg_out_valid,
	input  wire logic        msg_out_ready,
	output logic [7:0]       msg_out_dest,
	output logic [7:0]       msg_out_vector,
	output logic             msg_out_level,
	output logic             msg_on_sysbus,
	// Incoming messages
	input  wire logic        msg_in_valid,
	output logic             msg_in_ready,
	input  wire logic [7:0]  msg_in_dest,
	input  wire logic [7:0]  msg_in_vector,
	input  wire logic        msg_in_level,
	// Core delivery
	output logic             core_irq_valid,
	input  wire logic        core_irq_ack,
	output logic [7:0]       core_irq_vector,
	output logic             core_irq_nmi,
	output logic             core_irq_level
);
	localparam logic [31:0] BASE = `LIRH_BASE_ADDR;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] sy1_r, sy2_r;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sy1_r <= 3'h0;
			sy2_r <= 3'h0;
		end else begin
			sy1_r <= {legacy_irq, local_irq_pin_one, local_irq_pin_zero};
			sy2_r <= sy1_r;
		end
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic             aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [31:0]      awaddr_r, awaddr_nxt, wdata_r, wdata_nxt;
	logic [3:0]       wstrb_r, wstrb_nxt;
	logic             bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]       bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0]      rdata_r, rdata_nxt;
	logic [7:0]       id_r, id_nxt, dest_r, dest_nxt;
	logic             en_r, en_nxt, sysbus_r, sysbus_nxt, err_r, err_nxt;
	lirh_lvt_t        lvt_r [NSRC];
	lirh_lvt_t        lvt_nxt [NSRC];
	logic [31:0]      tinit_r, tinit_nxt, tcur_r, tcur_nxt;
	logic [NSRC-1:0]  pend_r, pend_nxt, prev_r, src_lvl;
	logic             out_valid_r, out_valid_nxt, out_self_r, out_self_nxt;
	logic             out_lvl_r, out_lvl_nxt;
	logic [7:0]       out_dest_r, out_dest_nxt, out_vec_r, out_vec_nxt;
	logic             rx_valid_r, rx_valid_nxt, rx_lvl_r, rx_lvl_nxt;
	logic [7:0]       rx_vec_r, rx_vec_nxt;
	lirh_dlv_e        dlv_r, dlv_nxt;
	logic [2:0]       dsrc_r, dsrc_nxt;
	logic [7:0]       dvec_r, dvec_nxt;
	logic             dnmi_r, dnmi_nxt, dlvl_r, dlvl_nxt;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	logic       wr_do, rd_do, wr_ok, rd_ok, err_evt, timer_evt, ack_fire;
	logic [7:0] wlvt, rlvt;
	logic [11:0] woff, roff;
	assign woff      = awaddr_r[11:0];
	assign roff      = s_axi_araddr[11:0];
	assign wlvt      = 8'(woff[11:4] - `LIRH_LVT_STEP);
	assign rlvt      = 8'(roff[11:4] - `LIRH_LVT_STEP);
	assign wr_do     = aw_have_r && w_have_r && !bvalid_r;
	assign rd_do     = s_axi_arvalid && s_axi_arready;
	assign ack_fire  = (dlv_r == LIRH_DLV_BUSY) && core_irq_ack;
	assign timer_evt = (tcur_r == 32'h0000_0001);

	always_comb begin
		wr_ok = 1'b0;
		if (awaddr_r[31:12] == BASE[31:12] && woff[3:0] == 4'h0 && wstrb_r == 4'hF) begin
			unique case (woff)
				`LIRH_OFF_ID, `LIRH_OFF_CTRL, `LIRH_OFF_ERR, `LIRH_OFF_ICR_LO,
				`LIRH_OFF_ICR_HI, `LIRH_OFF_TINIT: wr_ok = 1'b1;
				default: wr_ok = (wlvt < 8'(NSRC));
			endcase
		end
	end

	always_comb begin
		rd_ok     = s_axi_araddr[31:12] == BASE[31:12] && roff[3:0] == 4'h0;
		rdata_nxt = 32'h0000_0000;
		unique case (roff)
			`LIRH_OFF_ID:     rdata_nxt = {24'h00_0000, id_r};
			`LIRH_OFF_CTRL:   rdata_nxt = {22'h00_0000, sysbus_r, en_r, 8'h00};
			`LIRH_OFF_ERR:    rdata_nxt = {24'h00_0000, err_r, 7'h00};
			`LIRH_OFF_ICR_LO: rdata_nxt = {19'h0_0000, out_valid_r, 4'h0, out_vec_r};
			`LIRH_OFF_ICR_HI: rdata_nxt = {dest_r, 24'h00_0000};
			`LIRH_OFF_TINIT:  rdata_nxt = tinit_r;
			`LIRH_OFF_TCUR:   rdata_nxt = tcur_r;
			`LIRH_OFF_PEND:   rdata_nxt = 32'(pend_r);
			default: begin
				if (rlvt < 8'(NSRC))
					rdata_nxt = {15'h0000, lvt_r[rlvt[2:0]]};
				else
					rd_ok = 1'b0;
			end
		endcase
		// Refused reads return zero, never a neighbour's contents
		if (!rd_ok)
			rdata_nxt = 32'h0000_0000;
		err_evt = (wr_do && !wr_ok) || (rd_do && !rd_ok);
	end

	// ------------------------------------------------------------
	// AXI4-Lite handshakes
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready  = !w_have_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;

	always_comb begin
		aw_have_nxt = aw_have_r;
		w_have_nxt  = w_have_r;
		awaddr_nxt  = awaddr_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = bvalid_r && !s_axi_bready;
		bresp_nxt   = bresp_r;
		rvalid_nxt  = rvalid_r && !s_axi_rready;
		rresp_nxt   = rresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_nxt = 1'b1;
			awaddr_nxt  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata;
			wstrb_nxt  = s_axi_wstrb;
		end
		if (wr_do) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = wr_ok ? `LIRH_RESP_OK : `LIRH_RESP_ERR;
		end
		if (rd_do) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = rd_ok ? `LIRH_RESP_OK : `LIRH_RESP_ERR;
		end
	end

	// ------------------------------------------------------------
	// Registers, timer, sources, messages
	// ------------------------------------------------------------
	// Order: timer, thermal, perf, pin zero, pin one, error
	assign src_lvl = NSRC'({err_evt, sy2_r[1], sy2_r[0], perf_ovf, thermal_trip, timer_evt});

	always_comb begin
		id_nxt        = id_r;
		en_nxt        = en_r;
		sysbus_nxt    = sysbus_r;
		dest_nxt      = dest_r;
		tinit_nxt     = tinit_r;
		lvt_nxt       = lvt_r;
		tcur_nxt      = (tcur_r != 32'h0000_0000) ? tcur_r - 32'h0000_0001 : tcur_r;
		err_nxt       = err_r;
		out_valid_nxt = out_valid_r;
		out_self_nxt  = out_self_r;
		out_dest_nxt  = out_dest_r;
		out_vec_nxt   = out_vec_r;
		out_lvl_nxt   = out_lvl_r;
		rx_valid_nxt  = rx_valid_r && !(ack_fire && dsrc_r == `LIRH_SRC_RX);
		rx_vec_nxt    = rx_vec_r;
		rx_lvl_nxt    = rx_lvl_r;
		if (wr_do && wr_ok) begin
			unique case (woff)
				`LIRH_OFF_ID:     id_nxt = wdata_r[7:0];
				`LIRH_OFF_CTRL: begin
					en_nxt     = wdata_r[`LIRH_F_EN];
					sysbus_nxt = wdata_r[`LIRH_F_SYSBUS];
				end
				`LIRH_OFF_ERR:    err_nxt = 1'b0;
				`LIRH_OFF_ICR_HI: dest_nxt = wdata_r[31:24];
				`LIRH_OFF_TINIT: begin
					tinit_nxt = wdata_r;
					tcur_nxt  = wdata_r;
				end
				`LIRH_OFF_ICR_LO: begin
					if (!out_valid_r) begin
						out_valid_nxt = 1'b1;
						out_self_nxt  = wdata_r[`LIRH_F_SELF] || dest_r == id_r;
						out_dest_nxt  = wdata_r[`LIRH_F_SELF] ? id_r : dest_r;
						out_vec_nxt   = wdata_r[7:0];
						out_lvl_nxt   = wdata_r[`LIRH_F_TRIG];
					end
				end
				default: lvt_nxt[wlvt[2:0]] = wdata_r[16:0];
			endcase
		end
		if (err_evt)
			err_nxt = 1'b1;
		if (out_valid_r && !out_self_r && msg_out_ready)
			out_valid_nxt = 1'b0;
		if (out_valid_r && out_self_r && !rx_valid_r) begin
			out_valid_nxt = 1'b0;
			rx_valid_nxt  = en_r;
			rx_vec_nxt    = out_vec_r;
			rx_lvl_nxt    = out_lvl_r;
		end
		if (msg_in_valid && msg_in_ready && en_r &&
			(msg_in_dest == id_r || msg_in_dest == `LIRH_DEST_ALL)) begin
			rx_valid_nxt = 1'b1;
			rx_vec_nxt   = msg_in_vector;
			rx_lvl_nxt   = msg_in_level;
		end
		for (int i = 0; i < NSRC; i++) begin
			pend_nxt[i] = pend_r[i] && !(ack_fire && dsrc_r == 3'(i));
			if (en_r && !lvt_r[i][`LIRH_F_MASK] && src_lvl[i] &&
				(lvt_r[i][`LIRH_F_TRIG] || !prev_r[i]))
				pend_nxt[i] = 1'b1;
		end
	end

	assign msg_out_valid  = out_valid_r && !out_self_r;
	assign msg_out_dest   = out_dest_r;
	assign msg_out_vector = out_vec_r;
	assign msg_out_level  = out_lvl_r;
	assign msg_on_sysbus  = sysbus_r;
	assign msg_in_ready   = !rx_valid_r && !(out_valid_r && out_self_r);

	// ------------------------------------------------------------
	// Core delivery
	// ------------------------------------------------------------
	always_comb begin
		dlv_nxt  = dlv_r;
		dsrc_nxt = dsrc_r;
		dvec_nxt = dvec_r;
		dnmi_nxt = dnmi_r;
		dlvl_nxt = dlvl_r;
		unique case (dlv_r)
			LIRH_DLV_IDLE: begin
				if (!en_r) begin
					if (sy2_r[2]) begin
						dlv_nxt  = LIRH_DLV_BUSY;
						dsrc_nxt = `LIRH_SRC_LEGACY;
						dvec_nxt = legacy_vector;
						dnmi_nxt = 1'b0;
						dlvl_nxt = 1'b1;
					end
				end else if (rx_valid_r) begin
					dlv_nxt  = LIRH_DLV_BUSY;
					dsrc_nxt = `LIRH_SRC_RX;
					dvec_nxt = rx_vec_r;
					dnmi_nxt = 1'b0;
					dlvl_nxt = rx_lvl_r;
				end else begin
					for (int i = NSRC - 1; i >= 0; i--) begin
						if (pend_r[i]) begin
							dlv_nxt  = LIRH_DLV_BUSY;
							dsrc_nxt = 3'(i);
							dnmi_nxt = lvt_r[i][10:8] == `LIRH_MODE_NMI;
							dvec_nxt = dnmi_nxt ? `LIRH_VEC_NMI : lvt_r[i][7:0];
							dlvl_nxt = lvt_r[i][`LIRH_F_TRIG];
						end
					end
				end
			end
			LIRH_DLV_BUSY: if (core_irq_ack) dlv_nxt = LIRH_DLV_IDLE;
		endcase
	end

	assign core_irq_valid  = dlv_r == LIRH_DLV_BUSY;
	assign core_irq_vector = dvec_r;
	assign core_irq_nmi    = dnmi_r;
	assign core_irq_level  = dlvl_r;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			{aw_have_r, w_have_r, bvalid_r, rvalid_r} <= 4'h0;
			{awaddr_r, wdata_r, rdata_r} <= {3{32'h0000_0000}};
			{wstrb_r, bresp_r, rresp_r} <= 8'h00;
			{id_r, dest_r} <= {ID_RST, 8'h00};
			{en_r, sysbus_r, err_r} <= 3'b010;
			lvt_r   <= '{default: `LIRH_LVT_RST};
			{tinit_r, tcur_r} <= {2{32'h0000_0000}};
			pend_r  <= '0;
			prev_r  <= '0;
			{out_valid_r, out_self_r, out_lvl_r, rx_valid_r, rx_lvl_r} <= 5'h00;
			{out_dest_r, out_vec_r, rx_vec_r} <= 24'h00_0000;
			dlv_r   <= LIRH_DLV_IDLE;
			{dsrc_r, dvec_r, dnmi_r, dlvl_r} <= 13'h0000;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r  <= w_have_nxt;
			awaddr_r  <= awaddr_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			if (rd_do)
				rdata_r <= rdata_nxt;
			id_r        <= id_nxt;
			dest_r      <= dest_nxt;
			en_r        <= en_nxt;
			sysbus_r    <= sysbus_nxt;
			err_r       <= err_nxt;
			lvt_r       <= lvt_nxt;
			tinit_r     <= tinit_nxt;
			tcur_r      <= tcur_nxt;
			pend_r      <= pend_nxt;
			prev_r      <= src_lvl;
			out_valid_r <= out_valid_nxt;
			out_self_r  <= out_self_nxt;
			out_lvl_r   <= out_lvl_nxt;
			out_dest_r  <= out_dest_nxt;
			out_vec_r   <= out_vec_nxt;
			rx_valid_r  <= rx_valid_nxt;
			rx_vec_r    <= rx_vec_nxt;
			rx_lvl_r    <= rx_lvl_nxt;
			dlv_r       <= dlv_nxt;
			dsrc_r      <= dsrc_nxt;
			dvec_r      <= dvec_nxt;
			dnmi_r      <= dnmi_nxt;
			dlvl_r      <= dlvl_nxt;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	chk_nmi_vector: assert property (core_irq_valid && core_irq_nmi |-> core_irq_vector == 8'h02)
		else $error("nmi delivery without vector 2");
	chk_cmd_issue: assert property (wr_do && wr_ok && woff == 12'h300 && !out_valid_r
		|=> out_valid_r && out_vec_r == $past(wdata_r[7:0]))
		else $error("command write did not issue a message");
	chk_self_local: assert property (out_valid_r && out_self_r && !rx_valid_r
		|-> !msg_out_valid ##1 (!out_valid_r && rx_valid_r == $past(en_r)))
		else $error("self message not moved to receive slot");
	chk_rx_take: assert property (msg_in_valid && msg_in_ready && en_r && msg_in_dest == id_r
		|=> rx_valid_r && rx_vec_r == $past(msg_in_vector))
		else $error("addressed message not taken");
	chk_timer_pend: assert property (timer_evt && en_r && !lvt_r[0][16] |=> pend_r[0])
		else $error("timer expiry not pending");
	chk_err_flag: assert property (err_evt |=> err_r && (s_axi_bvalid || s_axi_rvalid))
		else $error("illegal access not flagged");
	chk_legacy_path: assert property (core_irq_valid && !en_r && $stable(en_r)
		&& dsrc_r == 3'h7 |-> core_irq_level)
		else $error("legacy delivery malformed");
	chk_pend_hold: assert property (pend_r[3] && !(ack_fire && dsrc_r == 3'h3) |=> pend_r[3])
		else $error("pending pin zero dropped before accept");
	chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp))
		else $error("write response withdrawn");
endmodule : lirh_hub

// >>> verification/lirh_far_model.sv
// Behavioural processor core and outgoing message sink facing the hub
module lirh_far_model (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// Pace of the core
	input  wire logic        slow,
	// Core delivery
	input  wire logic        core_irq_valid,
	output logic             core_irq_ack,
	input  wire logic [7:0]  core_irq_vector,
	input  wire logic        core_irq_nmi,
	output logic [8:0]       core_rec,
	output int               n_core,
	// Outgoing messages
	input  wire logic        msg_out_valid,
	output logic             msg_out_ready,
	input  wire logic [16:0] msg_out_word,
	output logic [16:0]      out_rec,
	output int               n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int wait_r;
	// ----------------------------------------
	// Acceptance
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			core_irq_ack  <= 1'b0;
			msg_out_ready <= 1'b0;
			wait_r        <= 0;
			n_core        <= 0;
			n_out         <= 0;
			core_rec      <= '0;
			out_rec       <= '0;
		end else begin
			// Sink stalls one cycle on every message, never ready ahead of valid
			msg_out_ready <= msg_out_valid && !msg_out_ready;
			if (msg_out_valid && msg_out_ready) begin
				out_rec <= msg_out_word;
				n_out   <= n_out + 1;
			end
			wait_r       <= core_irq_valid ? wait_r + 1 : 0;
			core_irq_ack <= core_irq_valid && !core_irq_ack && wait_r >= (slow ? 6 : 0);
			if (core_irq_valid && core_irq_ack) begin
				core_rec <= {core_irq_nmi, core_irq_vector};
				n_core   <= n_core + 1;
			end
		end
	end
endmodule : lirh_far_model

// >>> verification/lirh_hub_tb_top.sv
// Self-checking bench for the local interrupt routing hub
`include "lirh_defs.svh"
module lirh_hub_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] BA   = `LIRH_BASE_ADDR;
	localparam logic [1:0]  OK   = `LIRH_RESP_OK;
	localparam logic [1:0]  ER   = `LIRH_RESP_ERR;
	localparam logic [7:0]  MYID = 8'h5A;
	logic        core_clk, srst, awv, wv, bry, arv, rry, lgi, miv, mil, slow;
	logic [31:0] awa, wd, ara, r_dat;
	logic [7:0]  lgv, mid, mivec, mo_dst, mo_vec, c_vec;
	logic [3:0]  src, wsb;
	logic [1:0]  b_rsp, r_rsp;
	logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, mo_vld, mo_rdy, mo_lvl, sysbus, mi_rdy;
	logic        c_vld, c_ack, c_nmi, c_lvl, lvl_rec;
	logic [8:0]  core_rec;
	logic [16:0] out_rec;
	int          n_core, n_out, error_cnt, n_checks, seen;

	lirh_hub lirh_hub_i (.core_clk(core_clk), .srst(srst),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(aw_rdy), .s_axi_wdata(wd),
		.s_axi_wstrb(wsb), .s_axi_wvalid(wv), .s_axi_wready(w_rdy), .s_axi_bresp(b_rsp),
		.s_axi_bvalid(b_vld), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(ar_rdy), .s_axi_rdata(r_dat), .s_axi_rresp(r_rsp), .s_axi_rvalid(r_vld),
		.s_axi_rready(rry), .local_irq_pin_zero(src[2]), .local_irq_pin_one(src[3]),
		.perf_ovf(src[1]), .thermal_trip(src[0]), .legacy_irq(lgi), .legacy_vector(lgv),
		.msg_out_valid(mo_vld), .msg_out_ready(mo_rdy), .msg_out_dest(mo_dst),
		.msg_out_vector(mo_vec), .msg_out_level(mo_lvl), .msg_on_sysbus(sysbus),
		.msg_in_valid(miv), .msg_in_ready(mi_rdy), .msg_in_dest(mid), .msg_in_vector(mivec),
		.msg_in_level(mil), .core_irq_valid(c_vld), .core_irq_ack(c_ack),
		.core_irq_vector(c_vec), .core_irq_nmi(c_nmi), .core_irq_level(c_lvl));

	lirh_far_model lirh_far_model_i (.core_clk(core_clk), .srst(srst), .slow(slow),
		.core_irq_valid(c_vld), .core_irq_ack(c_ack), .core_irq_vector(c_vec),
		.core_irq_nmi(c_nmi), .core_rec(core_rec), .n_core(n_core), .msg_out_valid(mo_vld),
		.msg_out_ready(mo_rdy), .msg_out_word({mo_dst, mo_vec, mo_lvl}), .out_rec(out_rec),
		.n_out(n_out));

	always #10 core_clk = ~core_clk;

	// Trigger mode of the last delivery the core accepted
	always_ff @(posedge core_clk) begin
		if (c_vld && c_ack)
			lvl_rec <= c_lvl;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic conclude();
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tmo();
		error_cnt++;
		$display("[FAIL] %0t wait ran out", $time);
		conclude();
	endtask : tmo

	// Aligned write with the strobes held in wsb, address and data offered together
	task automatic wrc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic       ta, tw, done;
		logic [1:0] rs;
		done = 1'b0;
		@(posedge core_clk);
		awa <= a;
		wd  <= d;
		awv <= 1'b1;
		wv  <= 1'b1;
		bry <= 1'b1;
		for (int k = 0; k < 200 && !done; k++) begin
			@(negedge core_clk);
			ta   = awv && aw_rdy;
			tw   = wv && w_rdy;
			done = b_vld;
			rs   = b_rsp;
			@(posedge core_clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end
		if (!done) tmo();
		bry <= 1'b0;
		chk(rs, er);
	endtask : wrc

	task automatic rdc(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic        ta, done;
		logic [31:0] d;
		logic [1:0]  rs;
		done = 1'b0;
		@(posedge core_clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		for (int k = 0; k < 200 && !done; k++) begin
			@(negedge core_clk);
			ta   = arv && ar_rdy;
			done = r_vld;
			d    = r_dat;
			rs   = r_rsp;
			@(posedge core_clk);
			if (ta) arv <= 1'b0;
		end
		if (!done) tmo();
		rry <= 1'b0;
		chk(d, ed);
		chk(rs, er);
	endtask : rdc

	// Router side: one pin event becomes one addressed message
	task automatic msg_in(input logic [7:0] dst, input logic [7:0] vec);
		logic ta;
		ta = 1'b0;
		@(posedge core_clk);
		miv   <= 1'b1;
		mid   <= dst;
		mivec <= vec;
		mil   <= 1'b1;
		for (int k = 0; k < 200 && !ta; k++) begin
			@(negedge core_clk);
			ta = mi_rdy;
			@(posedge core_clk);
		end
		if (!ta) tmo();
		// Released lines show the inverse so stale fields never look valid
		miv   <= 1'b0;
		mid   <= ~dst;
		mivec <= ~vec;
		mil   <= 1'b0;
	endtask : msg_in

	task automatic core_wait(input int n, input logic [8:0] exp);
		seen += n;
		for (int k = 0; k < 400 && n_core < seen; k++)
			@(posedge core_clk);
		if (n_core < seen) tmo();
		chk(core_rec, exp);
	endtask : core_wait

	task automatic pulse(input logic [3:0] m);
		@(posedge core_clk);
		src <= m;
		repeat (3) @(posedge core_clk);
		src <= 4'h0;
	endtask : pulse

	// Level sources may deliver again while they fade; recount afterwards
	task automatic settle();
		repeat (30) @(posedge core_clk);
		seen = n_core;
	endtask : settle

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{awv, wv, bry, arv, rry, lgi, miv, mil, slow, src} = '0;
		{awa, wd, ara, lgv, mid, mivec} = '0;
		wsb = 4'hF;
		lvl_rec = 1'b0;
		core_clk = 1'b0;
		srst = 1'b1;
		error_cnt = 0;
		n_checks = 0;
		seen = 0;
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		chk(sysbus, 1'b1);
		rdc(BA + 32'h0000_0020, 32'h0000_0000, OK);
		rdc(BA + 32'h0000_00F0, 32'h0000_0200, OK);
		rdc(BA + 32'h0000_0320, 32'h0001_0000, OK);
		wrc(BA + 32'h0000_0020, {24'h0, MYID}, OK);
		rdc(BA + 32'h0000_0020, {24'h0, MYID}, OK);
		wsb <= 4'h3;
		wrc(BA + 32'h0000_0020, 32'h0000_0011, ER);
		wsb <= 4'hF;
		rdc(BA + 32'h0000_0020, {24'h0, MYID}, OK);
		rdc(BA + 32'h0000_0030, 32'h0000_0000, ER);
		rdc(BA + 32'h0000_0024, 32'h0000_0000, ER);
		rdc(BA + 32'h0000_1020, 32'h0000_0000, ER);
		wrc(BA + 32'h0000_0030, 32'h0000_0000, ER);
		rdc(BA + 32'h0000_0280, 32'h0000_0080, OK);
		wrc(BA + 32'h0000_0280, 32'h0000_0000, OK);
		rdc(BA + 32'h0000_0280, 32'h0000_0000, OK);
		lgv <= 8'h55;
		lgi <= 1'b1;
		core_wait(1, 9'h055);
		chk(lvl_rec, 1'b1);
		lgi <= 1'b0;
		wrc(BA + 32'h0000_00F0, 32'h0000_0100, OK);
		chk(sysbus, 1'b0);
		wrc(BA + 32'h0000_00F0, 32'h0000_0300, OK);
		chk(sysbus, 1'b1);
		settle();
		lgi <= 1'b1;
		repeat (20) @(posedge core_clk);
		chk(n_core, seen);
		lgi <= 1'b0;
		wrc(BA + 32'h0000_0310, 32'h0700_0000, OK);
		wrc(BA + 32'h0000_0300, 32'h0000_8041, OK);
		repeat (10) @(posedge core_clk);
		chk(n_out, 1);
		chk(out_rec, {8'h07, 8'h41, 1'b1});
		wrc(BA + 32'h0000_0300, 32'h0004_0042, OK);
		core_wait(1, 9'h042);
		chk(lvl_rec, 1'b0);
		wrc(BA + 32'h0000_0310, {MYID, 24'h0}, OK);
		wrc(BA + 32'h0000_0300, 32'h0000_0043, OK);
		core_wait(1, 9'h043);
		chk(n_out, 1);
		msg_in(MYID, 8'h61);
		core_wait(1, 9'h061);
		chk(lvl_rec, 1'b1);
		msg_in(8'hFF, 8'h62);
		core_wait(1, 9'h062);
		msg_in(8'h07, 8'h63);
		repeat (20) @(posedge core_clk);
		chk(n_core, seen);
		// Entry i gets vector 80h + 16*i; pin one entry in non-maskable mode
		for (int i = 0; i < 6; i++)
			wrc(BA + 32'h0000_0320 + 32'(16 * i), 32'(8'h80 + 8'(16 * i)) | (i == 4 ? 32'h0000_0400 : 32'h0), OK);
		wrc(BA + 32'h0000_0380, 32'h0000_0014, OK);
		core_wait(1, 9'h080);
		chk(lvl_rec, 1'b0);
		rdc(BA + 32'h0000_0390, 32'h0000_0000, OK);
		for (int i = 1; i < 5; i++) begin
			pulse(4'h1 << (i - 1));
			core_wait(1, i == 4 ? 9'h102 : {1'b0, 8'h80 + 8'(16 * i)});
		end
		rdc(BA + 32'h0000_0030, 32'h0000_0000, ER);
		core_wait(1, 9'h0D0);
		wrc(BA + 32'h0000_0350, 32'h0000_8000 | 32'h0000_00B0, OK);
		src <= 4'h4;
		core_wait(1, 9'h0B0);
		chk(lvl_rec, 1'b1);
		src <= 4'h0;
		settle();
		slow <= 1'b1;
		pulse(4'h3);
		core_wait(2, 9'h0A0);
		wrc(BA + 32'h0000_0330, 32'h0001_0090, OK);
		pulse(4'h1);
		repeat (20) @(posedge core_clk);
		chk(n_core, seen);
		conclude();
	end
endmodule : lirh_hub_tb_top
